// ### core/pstc_defs.svh
/*
 * Register offsets, field positions, reset values and the interrupt map of
 * the start-pattern, transmitter and packet configuration bank.
 * Assumes inclusion by its bare name; definitions only.
 */
`ifndef PSTC_DEFS_SVH
`define PSTC_DEFS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define PSTC_IDX_PAT_FIRST   8'h16
`define PSTC_IDX_PAT_SECOND  8'h17
`define PSTC_IDX_PAT_THIRD   8'h18
`define PSTC_IDX_PAT_LAST    8'h19
`define PSTC_IDX_TX_CFG      8'h1a
`define PSTC_IDX_CLK_CFG     8'h1b
`define PSTC_IDX_PKT_LEN     8'h1c
`define PSTC_IDX_NODE_ADDR   8'h1d
`define PSTC_IDX_PKT_CTL     8'h1e
`define PSTC_IDX_AUX_CTL     8'h20
`define PSTC_IDX_IRQ_STAT    8'h21
`define PSTC_IDX_IRQ_MASK    8'h22

// ****************************************************************
// Reset values
// ****************************************************************
`define PSTC_RST_PAT         8'h00
`define PSTC_RST_TX_CFG      8'h70
`define PSTC_RST_CLK_CFG     8'hbc
`define PSTC_RST_PKT_LEN     8'h00
`define PSTC_RST_NODE_ADDR   8'h00
`define PSTC_RST_PKT_CTL     8'h40
`define PSTC_RST_AUX_CTL     8'h00

// ****************************************************************
// Writable bit masks (unused bits read zero)
// ****************************************************************
`define PSTC_WM_TX_CFG       8'hfe
`define PSTC_WM_CLK_CFG      8'hfc
`define PSTC_WM_PKT_CTL      8'hfe
`define PSTC_WM_AUX_CTL      8'h83

// ****************************************************************
// Field positions
// ****************************************************************
`define PSTC_CRC_STAT_BIT    0
`define PSTC_FLUSH_BIT       7
`define PSTC_IRQ_CRC_OK      0
`define PSTC_IRQ_CRC_FAIL    1
`define PSTC_IRQ_ADDR_HIT    2
`define PSTC_IRQ_W           3

`endif

// ### core/pstc_pkg.sv
/*
 * Types for the configuration bank: packed register views and states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pstc_pkg;
  // Transmitter filter and power view
  typedef struct packed {
    logic [3:0] antialias;
    logic [2:0] power;
    logic       unused0;
  } pstc_tx_cfg_t;
  // Clock output view
  typedef struct packed {
    logic       clk_en;
    logic [4:0] div_m;
    logic [1:0] unused;
  } pstc_clk_cfg_t;
  // Packet control view
  typedef struct packed {
    logic       var_len;
    logic [1:0] preamble;
    logic       scramble;
    logic       crc_en;
    logic [1:0] addr_cmp;
    logic       crc_stat;
  } pstc_pkt_ctl_t;
  // Receive check result from the packet engine
  typedef struct packed {
    logic       done;
    logic       crc_ok;
    logic       addr_valid;
    logic [7:0] addr;
  } pstc_rx_chk_t;
  // Start pattern serialiser states
  typedef enum logic [1:0] {PSTC_IDLE, PSTC_SEND} pstc_state_t;
endpackage

// ### core/pstc_bank.sv
/*
 * Configuration register bank with APB slave, start-pattern byte sequencer,
 * buffered clock divider, address filter and CRC status / interrupt logic.
 * Assumes a single 40 MHz clock, APB master on the same clock, and a packet
 * engine that pulses receive check results synchronously.
 */
// How it works
// - pattern bytes sent 0x16 first, 0x19 last
// - size code selects one to four bytes
// - bits 7..4 antialias code, reset 0111
// - bits 3..1 power code, 000 highest
// - bit 7 gates the clock output
// - clock output is crystal over 2M, crystal itself at M zero
// - bit 7 enables Manchester both ways
// - seven-bit length field, resets zero
// - node address for receive comparison
// - bit 7 picks fixed or variable length
// - preamble bytes equal code plus one
// - bit 3 CRC, bit 4 scrambling enable
// - address compare codes 00 to 11
// - CRC status read-only, write one clears
// - failed CRC flushes FIFO unless kept
`timescale 1ns/100ps
`include "pstc_defs.svh"

module pstc_bank
  import pstc_pkg::*;
#(
  parameter int PAT_MAX = 4            // Largest start pattern, bytes
) (
  input  wire logic        MCLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        PAT_START,  // Pulse: begin sending start pattern
  input  wire logic        PAT_TAKE,   // Pulse: consumer took PAT_BYTE
  output logic      [7:0]  PAT_BYTE,
  output logic             PAT_VALID,
  input  wire pstc_rx_chk_t RX_CHK,    // Receive check result
  output logic             RX_ACCEPT,  // Address filter verdict
  output logic             FIFO_FLUSH, // Pulse: clear receive FIFO
  output logic             CLKOUT,
  output logic      [3:0]  TX_ANTIALIAS,
  output logic      [2:0]  TX_POWER,
  output logic             MANCH_EN,
  output logic      [6:0]  PKT_LEN,
  output logic             PKT_VAR_LEN,
  output logic      [2:0]  PREAMBLE_BYTES,
  output logic             SCRAMBLE_EN,
  output logic             CRC_EN,
  output logic             IRQ
);

  // Two-bit sequencer index serves exactly four pattern bytes
  if (PAT_MAX != 4) begin : g_pat_max
    $error("pstc_bank: PAT_MAX must be 4");
  end

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0]    pat_reg [0:3];   // Pattern bytes, index 0 sent first
  pstc_tx_cfg_t  tx_reg;          // Filter and power
  pstc_clk_cfg_t clk_reg;         // Clock output control
  logic [7:0]    len_reg;         // Manchester and length
  logic [7:0]    node_reg;        // Node address
  pstc_pkt_ctl_t ctl_reg;         // Packet control and CRC status
  logic [7:0]    aux_reg;         // Flush policy and pattern size
  logic [2:0]    irq_stat_reg;    // Sticky events
  logic [2:0]    irq_mask_reg;    // Event enables

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic       wr_en;               // Write takes effect this edge
  logic [7:0] widx;                // Register index of the access
  logic       hit;                 // Address is mapped
  logic [7:0] rd_byte;             // Read mux result

  assign PREADY  = 1'b1;           // Zero wait states
  assign widx    = PADDR[9:2];
  assign wr_en   = PSEL && PENABLE && PWRITE && hit;
  assign PSLVERR = PSEL && PENABLE && !hit;

  // Mask helper used for the transmitter, clock and auxiliary registers
  function automatic logic [7:0] wmask(input logic [7:0] d, input logic [7:0] m);
    return d & m;
  endfunction

  // Read mux; unused bits return zero
  always_comb begin
    hit     = (PADDR[1:0] == 2'b00) && (PADDR[31:10] == 22'h0);
    rd_byte = 8'h00;
    if (widx == `PSTC_IDX_PAT_FIRST) begin
      rd_byte = pat_reg[0];
    end else if (widx == `PSTC_IDX_PAT_SECOND) begin
      rd_byte = pat_reg[1];
    end else if (widx == `PSTC_IDX_PAT_THIRD) begin
      rd_byte = pat_reg[2];
    end else if (widx == `PSTC_IDX_PAT_LAST) begin
      rd_byte = pat_reg[3];
    end else if (widx == `PSTC_IDX_TX_CFG) begin
      rd_byte = tx_reg;
    end else if (widx == `PSTC_IDX_CLK_CFG) begin
      rd_byte = clk_reg;
    end else if (widx == `PSTC_IDX_PKT_LEN) begin
      rd_byte = len_reg;
    end else if (widx == `PSTC_IDX_NODE_ADDR) begin
      rd_byte = node_reg;
    end else if (widx == `PSTC_IDX_PKT_CTL) begin
      rd_byte = ctl_reg;
    end else if (widx == `PSTC_IDX_AUX_CTL) begin
      rd_byte = aux_reg;
    end else if (widx == `PSTC_IDX_IRQ_STAT) begin
      rd_byte = {5'h00, irq_stat_reg};
    end else if (widx == `PSTC_IDX_IRQ_MASK) begin
      rd_byte = {5'h00, irq_mask_reg};
    end else begin
      hit = 1'b0;                                        // Unmapped: error
    end
  end

  // Read data registered at the setup cycle so it is stable in access
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= {24'h00_0000, rd_byte};
    end
  end

  // ****************************************************************
  // Configuration writes
  // ****************************************************************
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < 4; i++) begin
        pat_reg[i] <= `PSTC_RST_PAT;
      end
      tx_reg   <= `PSTC_RST_TX_CFG;
      clk_reg  <= `PSTC_RST_CLK_CFG;
      len_reg  <= `PSTC_RST_PKT_LEN;
      node_reg <= `PSTC_RST_NODE_ADDR;
      aux_reg  <= `PSTC_RST_AUX_CTL;
    end else if (wr_en) begin
      if (widx == `PSTC_IDX_PAT_FIRST) begin
        pat_reg[0] <= PWDATA[7:0];
      end else if (widx == `PSTC_IDX_PAT_SECOND) begin
        pat_reg[1] <= PWDATA[7:0];
      end else if (widx == `PSTC_IDX_PAT_THIRD) begin
        pat_reg[2] <= PWDATA[7:0];
      end else if (widx == `PSTC_IDX_PAT_LAST) begin
        pat_reg[3] <= PWDATA[7:0];
      end else if (widx == `PSTC_IDX_TX_CFG) begin
        tx_reg <= wmask(PWDATA[7:0], `PSTC_WM_TX_CFG);
      end else if (widx == `PSTC_IDX_CLK_CFG) begin
        clk_reg <= wmask(PWDATA[7:0], `PSTC_WM_CLK_CFG);
      end else if (widx == `PSTC_IDX_PKT_LEN) begin
        len_reg <= PWDATA[7:0];
      end else if (widx == `PSTC_IDX_NODE_ADDR) begin
        node_reg <= PWDATA[7:0];
      end else if (widx == `PSTC_IDX_AUX_CTL) begin
        aux_reg <= wmask(PWDATA[7:0], `PSTC_WM_AUX_CTL);
      end
    end
  end

  // ****************************************************************
  // Packet control and CRC status
  // ****************************************************************
  logic ctl_wr;                    // Write to packet control
  logic crc_clr;                   // Write-one-to-clear of status
  logic crc_set;                   // Successful check this cycle
  assign ctl_wr  = wr_en && (widx == `PSTC_IDX_PKT_CTL);
  assign crc_clr = ctl_wr && PWDATA[`PSTC_CRC_STAT_BIT];
  assign crc_set = RX_CHK.done && ctl_reg.crc_en && RX_CHK.crc_ok;

  // Status bit: set beats clear so a result in the clear cycle survives
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ctl_reg <= `PSTC_RST_PKT_CTL;
    end else begin
      if (ctl_wr) begin
        ctl_reg[7:1] <= PWDATA[7:1];
      end
      if (crc_set) begin
        ctl_reg.crc_stat <= 1'b1;
      end else if (crc_clr || (RX_CHK.done && ctl_reg.crc_en)) begin
        ctl_reg.crc_stat <= 1'b0;
      end
    end
  end

  // Flush on failure unless the keep bit is set
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      FIFO_FLUSH <= 1'b0;
    end else begin
      FIFO_FLUSH <= RX_CHK.done && ctl_reg.crc_en && !RX_CHK.crc_ok
                    && !aux_reg[`PSTC_FLUSH_BIT];
    end
  end

  // ****************************************************************
  // Address filter
  // ****************************************************************
  function automatic logic addr_ok(input logic [1:0] mode, input logic [7:0] a,
                                   input logic [7:0] node);
    case (mode)
      2'b00:   return 1'b1;
      2'b01:   return a == node;
      2'b10:   return (a == node) || (a == 8'h00);
      default: return (a == node) || (a == 8'h00) || (a == 8'hff);
    endcase
  endfunction

  logic addr_hit;                  // Verdict for current received address
  assign addr_hit = addr_ok(ctl_reg.addr_cmp, RX_CHK.addr, node_reg);

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      RX_ACCEPT <= 1'b0;
    end else if (RX_CHK.addr_valid) begin
      RX_ACCEPT <= addr_hit;
    end
  end

  // ****************************************************************
  // Interrupts: sticky, write one to clear, masked OR
  // ****************************************************************
  logic [2:0] ev;                  // Event pulses
  assign ev[`PSTC_IRQ_CRC_OK]   = crc_set;
  assign ev[`PSTC_IRQ_CRC_FAIL] = RX_CHK.done && ctl_reg.crc_en && !RX_CHK.crc_ok;
  assign ev[`PSTC_IRQ_ADDR_HIT] = RX_CHK.addr_valid && addr_hit;

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
    end else begin
      // Set wins over a simultaneous clear
      if (wr_en && widx == `PSTC_IDX_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~PWDATA[2:0]) | ev;
      end else begin
        irq_stat_reg <= irq_stat_reg | ev;
      end
      if (wr_en && widx == `PSTC_IDX_IRQ_MASK) begin
        irq_mask_reg <= PWDATA[2:0];
      end
    end
  end
  assign IRQ = |(irq_stat_reg & irq_mask_reg);

  // ****************************************************************
  // Start pattern sequencer
  // ****************************************************************
  pstc_state_t state_reg;          // Idle or sending
  logic [1:0]  pat_idx_reg;        // Byte being offered
  logic [1:0]  pat_last;           // Index of final byte
  assign pat_last = aux_reg[1:0];

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg   <= PSTC_IDLE;
      pat_idx_reg <= 2'h0;
    end else begin
      case (state_reg)
        PSTC_IDLE: begin
          if (PAT_START) begin
            state_reg   <= PSTC_SEND;
            pat_idx_reg <= 2'h0;
          end
        end
        PSTC_SEND: begin
          if (PAT_TAKE) begin
            if (pat_idx_reg == pat_last) begin
              state_reg <= PSTC_IDLE;
            end else begin
              pat_idx_reg <= pat_idx_reg + 2'h1;
            end
          end
        end
        default: state_reg <= PSTC_IDLE;
      endcase
    end
  end
  assign PAT_VALID = (state_reg == PSTC_SEND);

  // Offered byte kept in a flop; loaded with the byte the index moves to.
  // A rewrite of the byte already on offer only shows on the next send.
  logic [7:0] pat_byte_reg;        // Byte on offer
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      pat_byte_reg <= `PSTC_RST_PAT;
    end else if (state_reg == PSTC_IDLE && PAT_START) begin
      pat_byte_reg <= pat_reg[0];
    end else if (PAT_VALID && PAT_TAKE && pat_idx_reg != pat_last) begin
      pat_byte_reg <= pat_reg[pat_idx_reg + 2'h1];
    end
  end
  assign PAT_BYTE  = pat_byte_reg;

  // ****************************************************************
  // Buffered clock output: toggles every M cycles, or passes clock
  // ****************************************************************
  logic [4:0] div_cnt_reg;         // Half-period counter
  logic       div_clk_reg;         // Divided clock
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      div_cnt_reg <= 5'h00;
      div_clk_reg <= 1'b0;
    end else if (div_cnt_reg + 5'h01 >= clk_reg.div_m) begin
      div_cnt_reg <= 5'h00;
      div_clk_reg <= ~div_clk_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 5'h01;
    end
  end
  // M of zero passes the clock straight through; glitch risk accepted
  assign CLKOUT = clk_reg.clk_en &&
                  ((clk_reg.div_m == 5'h00) ? MCLK : div_clk_reg);

  // ****************************************************************
  // Configuration outputs
  // ****************************************************************
  assign TX_ANTIALIAS   = tx_reg.antialias;
  assign TX_POWER       = tx_reg.power;
  assign MANCH_EN       = len_reg[7];
  assign PKT_LEN        = len_reg[6:0];
  assign PKT_VAR_LEN    = ctl_reg.var_len;
  assign PREAMBLE_BYTES = {1'b0, ctl_reg.preamble} + 3'h1;
  assign SCRAMBLE_EN    = ctl_reg.scramble;
  assign CRC_EN         = ctl_reg.crc_en;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_PAT_FIRST: assert property (@(posedge MCLK) disable iff (!RST_B)
    (state_reg == PSTC_IDLE && PAT_START) |=> (PAT_BYTE == pat_reg[0]))
    else $error("pattern did not start at first byte");
  AST_PAT_END: assert property (@(posedge MCLK) disable iff (!RST_B)
    (PAT_VALID && PAT_TAKE && pat_idx_reg == pat_last) |=> !PAT_VALID)
    else $error("pattern ran past configured size");
  AST_PAT_STEP: assert property (@(posedge MCLK) disable iff (!RST_B)
    (PAT_VALID && PAT_TAKE && pat_idx_reg != pat_last)
      |=> (pat_idx_reg == $past(pat_idx_reg) + 2'h1))
    else $error("pattern byte order broken");
  AST_CLK_OFF: assert property (@(posedge MCLK) disable iff (!RST_B)
    !clk_reg.clk_en |-> !CLKOUT)
    else $error("clock output driven while disabled");
  AST_CRC_SET: assert property (@(posedge MCLK) disable iff (!RST_B)
    crc_set |=> ctl_reg.crc_stat)
    else $error("CRC success not recorded");
  AST_CRC_CLR: assert property (@(posedge MCLK) disable iff (!RST_B)
    (crc_clr && !RX_CHK.done) |=> !ctl_reg.crc_stat)
    else $error("CRC status not cleared");
  AST_FLUSH: assert property (@(posedge MCLK) disable iff (!RST_B)
    ev[`PSTC_IRQ_CRC_FAIL] |=> (FIFO_FLUSH == !$past(aux_reg[`PSTC_FLUSH_BIT])))
    else $error("flush policy not followed");
  AST_ADDR: assert property (@(posedge MCLK) disable iff (!RST_B)
    (RX_CHK.addr_valid && ctl_reg.addr_cmp == 2'b01 && RX_CHK.addr != node_reg)
      |=> !RX_ACCEPT)
    else $error("foreign address accepted");
  AST_PREAMB: assert property (@(posedge MCLK) disable iff (!RST_B)
    (PREAMBLE_BYTES >= 3'h1) && (PREAMBLE_BYTES <= 3'h4) &&
    (PREAMBLE_BYTES[1:0] == ctl_reg.preamble + 2'h1))
    else $error("preamble count wrong");
  AST_UNUSED: assert property (@(posedge MCLK) disable iff (!RST_B)
    (tx_reg.unused0 == 1'b0) && (clk_reg.unused == 2'b00))
    else $error("unused bit stored");

  COV_PAT4: cover property (@(posedge MCLK) disable iff (!RST_B)
    PAT_VALID && PAT_TAKE && pat_idx_reg == 2'h3);
  COV_FLUSH: cover property (@(posedge MCLK) disable iff (!RST_B) FIFO_FLUSH);
  COV_IRQ: cover property (@(posedge MCLK) disable iff (!RST_B) IRQ);

endmodule

// ### dv/pstc_host.sv
/*
 * APB host model standing in front of the configuration bank.
 * Assumes one clock shared with the bank and a slave that raises pready.
 */
`timescale 1ns/100ps

module pstc_host (
  input  wire logic        mclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // ****************************************************************
  // Idle bus from time zero
  // ****************************************************************
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 32'h0;
    pwdata  = 32'h0;
  end

  // One transfer; word index times four gives the byte address
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd, output logic err);
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {22'h0, idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge mclk);
    penable <= 1'b1;
    // Wait for the slave; only the bench watchdog ends a dead wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd  = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines flip so stale values never look valid
    paddr   <= ~paddr;
    pwdata  <= ~pwdata;
  endtask
endmodule

// ### dv/pstc_bank_bench.sv
/*
 * Self-checking bench: register table loop, then pattern, CRC, filter,
 * unmapped-address error, clock output and reset cases. Assumes the bank and the host model.
 */
`timescale 1ns/100ps
`include "pstc_defs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("wrong value at %0t: got %0h want %0h", $time, (a), (b)); end end

module pstc_bank_bench import pstc_pkg::*;;
  // ****************************************************************
  // Signals and counters
  // ****************************************************************
  typedef struct packed {logic [7:0] idx, wd, rst, rd;} pstc_row_t;
  logic mclk = 1'b0, rst_b = 1'b0, pat_start = 1'b0, pat_take = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, pat_valid, rx_accept, fifo_flush;
  logic clkout, manch_en, pkt_var_len, scramble_en, crc_en, irq, e, exp;
  logic [31:0] paddr, pwdata, prdata;
  logic [7:0]  pat_byte, d;
  logic [6:0]  pkt_len;
  logic [3:0]  tx_antialias;
  logic [2:0]  tx_power, preamble_bytes;
  pstc_rx_chk_t rx_chk = '0;
  int num_errors = 0, check_count = 0, clk_edges = 0;
  // Index, write, reset value, readback (unused bits read zero)
  pstc_row_t rows [10] = '{'{8'h16, 8'ha5, 8'h00, 8'ha5}, '{8'h17, 8'h3c, 8'h00, 8'h3c},
    '{8'h18, 8'h81, 8'h00, 8'h81}, '{8'h19, 8'h7e, 8'h00, 8'h7e},
    '{8'h1a, 8'hff, 8'h70, 8'hfe}, '{8'h1b, 8'hff, 8'hbc, 8'hfc},
    '{8'h1c, 8'hff, 8'h00, 8'hff}, '{8'h1d, 8'h5a, 8'h00, 8'h5a},
    '{8'h1e, 8'hfe, 8'h40, 8'hfe}, '{`PSTC_IDX_AUX_CTL, 8'hff, 8'h00, 8'h83}};
  logic [7:0] addrs [4] = '{8'h5a, 8'h00, 8'hff, 8'h33};

  always #12.5 mclk = ~mclk;
  // Divided clock edge counter
  always @(posedge clkout) clk_edges++;

  pstc_host pstc_host_i (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  pstc_bank pstc_bank_i (.MCLK(mclk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PAT_START(pat_start), .PAT_TAKE(pat_take), .PAT_BYTE(pat_byte),
    .PAT_VALID(pat_valid), .RX_CHK(rx_chk), .RX_ACCEPT(rx_accept), .FIFO_FLUSH(fifo_flush),
    .CLKOUT(clkout), .TX_ANTIALIAS(tx_antialias), .TX_POWER(tx_power), .MANCH_EN(manch_en),
    .PKT_LEN(pkt_len), .PKT_VAR_LEN(pkt_var_len), .PREAMBLE_BYTES(preamble_bytes),
    .SCRAMBLE_EN(scramble_en), .CRC_EN(crc_en), .IRQ(irq));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    logic [7:0] x;
    logic y;
    pstc_host_i.xfer(1'b1, i, v, x, y);
    @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] v);
    logic y;
    pstc_host_i.xfer(1'b0, i, 8'h00, v, y);
  endtask
  // Receive check pulse from the packet engine side
  task automatic rx_event(input logic ok, input logic [7:0] a, input logic av);
    @(posedge mclk);
    rx_chk <= '{done: ~av, crc_ok: ok, addr_valid: av, addr: a};
    @(posedge mclk);
    rx_chk <= '0;
    @(negedge mclk);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog at 20000 cycles, well beyond the expected few hundred cycles
  initial begin
    #(25 * 20000);
    num_errors++;
    conclude();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge mclk);
    `CHK({tx_antialias, tx_power, preamble_bytes}, {4'h7, 3'h0, 3'h3})
    rst_b <= 1'b1;
    for (int r = 0; r < 10; r++) begin
      rd(rows[r].idx, d);
      `CHK(d, rows[r].rst)
      wr(rows[r].idx, rows[r].wd);
      rd(rows[r].idx, d);
      `CHK(d, rows[r].rd)
    end
    `CHK(prdata, 32'h0000_0083)
    `CHK({tx_antialias, tx_power, manch_en, pkt_len}, {4'hf, 3'h7, 1'b1, 7'h7f})
    `CHK({pkt_var_len, preamble_bytes, scramble_en, crc_en}, {1'b1, 3'h4, 2'b11})
    $display("test registers done");
    // Sizes one to four; a start request mid-send must be ignored
    for (int s = 0; s < 4; s++) begin
      wr(`PSTC_IDX_AUX_CTL, 8'(s));
      @(posedge mclk) pat_start <= 1'b1;
      @(posedge mclk) pat_start <= 1'b0;
      for (int k = 0; k <= s; k++) begin
        @(negedge mclk);
        `CHK({pat_valid, pat_byte}, {1'b1, rows[k].wd})
        @(posedge mclk) pat_take <= 1'b1;
        pat_start <= (k == 1);
        @(posedge mclk) pat_take <= 1'b0;
        pat_start <= 1'b0;
      end
      repeat (2) @(negedge mclk);
      `CHK(pat_valid, 1'b0)
    end
    $display("test pattern done");
    // CRC result, interrupt mask and clear, flush control
    wr(8'h1e, 8'h08);
    wr(`PSTC_IDX_IRQ_MASK, 8'h00);
    rx_event(1'b1, 8'h00, 1'b0);
    `CHK({fifo_flush, irq}, 2'b00)
    rd(8'h1e, d);
    `CHK(d, 8'h09)
    wr(`PSTC_IDX_IRQ_MASK, 8'h01);
    `CHK(irq, 1'b1)
    wr(`PSTC_IDX_IRQ_STAT, 8'h01);
    `CHK(irq, 1'b0)
    wr(8'h1e, 8'h09);
    rd(8'h1e, d);
    `CHK(d, 8'h08)
    rx_event(1'b0, 8'h00, 1'b0);
    `CHK(fifo_flush, 1'b1)
    @(negedge mclk);
    `CHK(fifo_flush, 1'b0)
    rd(`PSTC_IDX_IRQ_STAT, d);
    `CHK(d, 8'h02)
    wr(`PSTC_IDX_AUX_CTL, 8'h80);
    rx_event(1'b0, 8'h00, 1'b0);
    `CHK(fifo_flush, 1'b0)
    wr(`PSTC_IDX_IRQ_STAT, 8'hff);
    wr(8'h1e, 8'h00);
    rx_event(1'b0, 8'h00, 1'b0);
    rd(`PSTC_IDX_IRQ_STAT, d);
    `CHK(d, 8'h00)
    $display("test crc done");
    // Every comparison code against node, zero, all-ones and other
    wr(8'h1d, 8'h5a);
    for (int c = 0; c < 4; c++) begin
      wr(8'h1e, {5'h0, 2'(c), 1'b0});
      for (int i = 0; i < 4; i++) begin
        exp = (c == 0) || (addrs[i] == 8'h5a) || (c >= 2 && addrs[i] == 8'h00) ||
              (c == 3 && addrs[i] == 8'hff);
        rx_event(1'b0, addrs[i], 1'b1);
        `CHK(rx_accept, exp)
      end
    end
    rd(`PSTC_IDX_IRQ_STAT, d);
    `CHK(d, 8'h04)
    $display("test filter done");
    // Unmapped word: error answer, reads zero
    pstc_host_i.xfer(1'b0, 8'h3f, 8'h00, d, e);
    `CHK({e, d}, {1'b1, 8'h00})
    $display("test unmapped done");
    // Clock output: M=2, M=0 passthrough, disabled
    for (int t = 0; t < 3; t++) begin
      wr(8'h1b, (t == 0) ? 8'h88 : (t == 1) ? 8'h80 : 8'h08);
      repeat (40) @(negedge mclk);
      clk_edges = 0;
      repeat (40) @(negedge mclk);
      `CHK(clk_edges, (t == 0) ? 10 : (t == 1) ? 40 : 0)
    end
    $display("test clock done");
    // Mid-run reset returns transmitter, length, clock and interrupt state to reset values
    wr(`PSTC_IDX_IRQ_MASK, 8'h04);
    `CHK(irq, 1'b1)
    @(posedge mclk) rst_b <= 1'b0;
    @(negedge mclk);
    `CHK({tx_antialias, tx_power, pkt_len, irq}, {4'h7, 3'h0, 7'h00, 1'b0})
    @(posedge mclk) rst_b <= 1'b1;
    rd(`PSTC_IDX_CLK_CFG, d);
    `CHK(d, 8'hbc)
    $display("test reset done");
    conclude();
  end
endmodule
